// ---- include/eeprom_port_defs.svh ----
`ifndef EEPROM_PORT_DEFS_SVH
`define EEPROM_PORT_DEFS_SVH
`define ARRAY_TYPE_CODE 4'hA
`define IDPAGE_TYPE_CODE 4'hB
`define ADDR_W 11
`define PAGE_BITS 4
`define IDPAGE_SEL_BIT 7
`define BIT_CNT_LAST 4'h8
`define WRITE_TIME_NS 4000000
`define CLK_PERIOD_NS 8
`define MEM_RESET_BYTE 8'hFF
`endif

// ---- include/eeprom_port_pkg.sv ----
package eeprom_port_pkg;
   // byte phase of a transfer
   typedef enum logic [2:0] {
      PH_IDLE = 3'b000,
      PH_DEVADDR = 3'b001,
      PH_WORDADDR = 3'b010,
      PH_WDATA = 3'b011,
      PH_RDATA = 3'b100
   } phase_t;
   // one byte headed for the page buffer
   typedef struct packed {
      logic idpage;
      logic [3:0] offs;
      logic [7:0] data;
   } wr_word_t;
   // bus conditions seen this cycle
   typedef struct packed {
      logic start;
      logic stop;
      logic rise;
      logic fall;
   } bus_ev_t;
endpackage

// ---- hw/eeprom_slave_port.sv ----
`timescale 1ns/10ps
`include "eeprom_port_defs.svh"
// page buffer fifo, width and depth parameters
module page_fifo
   import eeprom_port_pkg::*;
#(
   parameter int WIDTH = 13,
   parameter int DEPTH = 16
)
(
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic ce,
   input wire logic [WIDTH-1:0] in_data,
   input wire logic in_valid,
   output logic in_ready,
   output logic [WIDTH-1:0] out_data,
   output logic out_valid,
   input wire logic out_ready
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW:0] wp_r;
   logic [AW:0] rp_r;
   assign in_ready = (wp_r[AW] == rp_r[AW]) || (wp_r[AW-1:0] != rp_r[AW-1:0]);
   assign out_valid = wp_r != rp_r;
   assign out_data = mem[rp_r[AW-1:0]];
   // pointers with wrap bit give honest full and empty
   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
      begin
         wp_r <= '0;
         rp_r <= '0;
      end
      else if (ce)
      begin
         if (in_valid && in_ready)
            wp_r <= wp_r + 1'b1;
         if (out_valid && out_ready)
            rp_r <= rp_r + 1'b1;
      end
   end
   // storage, no reset needed
   always_ff @(posedge clk_sys)
   begin
      if (ce && in_valid && in_ready)
         mem[wp_r[AW-1:0]] <= in_data;
   end
endmodule // page_fifo

module eeprom_slave_port
   import eeprom_port_pkg::*;
#(
   parameter int WRITE_TIME_NS = `WRITE_TIME_NS,
   parameter int WRITE_CYCLES = (WRITE_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS,
   parameter int FIFO_DEPTH = 16
)
(
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic ce,
   input wire logic scl_in,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe_n,
   input wire logic write_protect,
   input wire logic unlock_dev_reg,
   output logic busy,
   output logic standby
);
   localparam int CW = $clog2(WRITE_CYCLES + 1);
   logic [2:0] scl_s_r;
   logic [2:0] sda_s_r;
   logic scl_r;
   logic sda_r;
   bus_ev_t ev;
   phase_t phase_r;
   logic [7:0] sh_r;
   logic [3:0] bit_r;
   logic ack_slot_r;
   logic acked_r;
   logic rd_r;
   logic idsel_r;
   logic [`ADDR_W-1:0] addr_r;
   logic wr_pend_r;
   logic [CW-1:0] wcnt_r;
   logic unlocked_r;
   logic [7:0] mem [1 << `ADDR_W];
   logic [7:0] idmem [1 << `PAGE_BITS];
   logic [7:0] rbyte_r;
   logic [`ADDR_W-`PAGE_BITS-1:0] wpage_r;
   wr_word_t fin;
   wr_word_t fout;
   logic fin_valid;
   logic fin_ready;
   logic fout_valid;
   logic fout_ready;
   logic sda_low_nxt;

   // three stage sync; change counts when stages two and three agree
   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
      begin
         scl_s_r <= 3'h7;
         sda_s_r <= 3'h7;
         scl_r <= 1'b1;
         sda_r <= 1'b1;
      end
      else if (ce)
      begin
         scl_s_r <= {scl_s_r[1:0], scl_in};
         sda_s_r <= {sda_s_r[1:0], sda_in};
         if (scl_s_r[1] == scl_s_r[2])
            scl_r <= scl_s_r[2];
         if (sda_s_r[1] == sda_s_r[2])
            sda_r <= sda_s_r[2];
      end
   end

   // edge and condition decode on filtered levels
   always_comb
   begin
      ev.rise = !scl_r && scl_s_r[1] && scl_s_r[2];
      ev.fall = scl_r && !scl_s_r[1] && !scl_s_r[2];
      ev.start = scl_r && sda_r && !sda_s_r[1] && !sda_s_r[2];
      ev.stop = scl_r && !sda_r && sda_s_r[1] && sda_s_r[2];
   end

   // unlock is sticky until reset
   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
         unlocked_r <= 1'b0;
      else if (ce && unlock_dev_reg)
         unlocked_r <= 1'b1;
   end

   // bit framing and byte phases; start always restarts, busy ignores all
   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
      begin
         phase_r <= PH_IDLE;
         sh_r <= 8'h00;
         bit_r <= 4'h0;
         ack_slot_r <= 1'b0;
         acked_r <= 1'b0;
         rd_r <= 1'b0;
         idsel_r <= 1'b0;
      end
      else if (ce)
      begin
         if (ev.start)
         begin
            phase_r <= PH_DEVADDR;
            bit_r <= 4'h0;
            ack_slot_r <= 1'b0;
            acked_r <= 1'b0;
         end
         else if (ev.stop || wr_pend_r)
            phase_r <= PH_IDLE;
         else if (phase_r != PH_IDLE && ev.rise && !ack_slot_r)
         begin
            sh_r <= {sh_r[6:0], sda_r};
            bit_r <= bit_r + 4'h1;
         end
         else if (phase_r != PH_IDLE && ev.rise && ack_slot_r && rd_r && sda_r)
            phase_r <= PH_IDLE; // master nack ends read
         else if (phase_r != PH_IDLE && ev.fall && bit_r == `BIT_CNT_LAST)
         begin
            bit_r <= 4'h0;
            ack_slot_r <= 1'b1;
            acked_r <= 1'b0;
            unique case (phase_r)
               PH_DEVADDR:
               begin
                  if (sh_r[7:4] == `ARRAY_TYPE_CODE || sh_r[7:4] == `IDPAGE_TYPE_CODE)
                  begin
                     acked_r <= !busy;
                     rd_r <= sh_r[0];
                     idsel_r <= sh_r[7:4] == `IDPAGE_TYPE_CODE;
                     phase_r <= busy ? PH_IDLE : (sh_r[0] ? PH_RDATA : PH_WORDADDR);
                  end
                  else
                     phase_r <= PH_IDLE;
               end
               PH_WORDADDR:
               begin
                  acked_r <= 1'b1;
                  phase_r <= PH_WDATA;
               end
               PH_WDATA:
                  acked_r <= fin_ready;
               PH_RDATA:
                  acked_r <= 1'b0;
               default:
                  phase_r <= PH_IDLE;
            endcase
         end
         else if (ev.fall && ack_slot_r)
            ack_slot_r <= 1'b0;
      end
   end

   // address counter: block bits, word address, in-page wrap on writes, full roll on reads
   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
      begin
         addr_r <= '0;
         wpage_r <= '0;
      end
      else if (ce && ev.fall && bit_r == `BIT_CNT_LAST && !ack_slot_r)
      begin
         if (phase_r == PH_DEVADDR && sh_r[7:4] == `ARRAY_TYPE_CODE)
            addr_r[`ADDR_W-1:`ADDR_W-3] <= sh_r[3:1];
         else if (phase_r == PH_WORDADDR)
         begin
            addr_r[7:0] <= sh_r;
            wpage_r <= {addr_r[`ADDR_W-1:8], sh_r[7:`PAGE_BITS]};
         end
         else if (phase_r == PH_WDATA)
            addr_r[`PAGE_BITS-1:0] <= addr_r[`PAGE_BITS-1:0] + 4'h1;
         else if (phase_r == PH_RDATA)
            addr_r <= addr_r + 11'h001;
      end
   end

   // fifo entry for each received data byte; blocked writes are simply not queued
   always_comb
   begin
      fin.idpage = idsel_r;
      fin.offs = addr_r[`PAGE_BITS-1:0];
      fin.data = sh_r;
      fin_valid = ce && ev.fall && bit_r == `BIT_CNT_LAST && phase_r == PH_WDATA && !ack_slot_r
         && (unlocked_r || !write_protect)
         && !(idsel_r && addr_r[`IDPAGE_SEL_BIT]);
      fout_ready = wr_pend_r && wcnt_r == CW'(1);
   end

   page_fifo #(.WIDTH($bits(wr_word_t)), .DEPTH(FIFO_DEPTH)) u_page_fifo (
      .clk_sys(clk_sys),
      .rst(rst),
      .ce(ce),
      .in_data(fin),
      .in_valid(fin_valid),
      .in_ready(fin_ready),
      .out_data(fout),
      .out_valid(fout_valid),
      .out_ready(fout_ready)
   );

   // programming timer; stop after data starts it, drain commits at end
   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
      begin
         wr_pend_r <= 1'b0;
         wcnt_r <= '0;
      end
      else if (ce)
      begin
         if (!wr_pend_r && ev.stop && fout_valid)
         begin
            wr_pend_r <= 1'b1;
            wcnt_r <= CW'(WRITE_CYCLES);
         end
         else if (wr_pend_r && wcnt_r > CW'(1))
            wcnt_r <= wcnt_r - CW'(1);
         else if (wr_pend_r && !fout_valid)
            wr_pend_r <= 1'b0;
      end
   end

   // array commit: page bytes written one per clock once the timer reaches one
   always_ff @(posedge clk_sys)
   begin
      if (ce && fout_valid && fout_ready)
      begin
         if (fout.idpage)
            idmem[fout.offs] <= fout.data;
         else
            mem[{wpage_r, fout.offs}] <= fout.data;
      end
   end

   // read byte fetched at the read address ack
   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
         rbyte_r <= `MEM_RESET_BYTE;
      else if (ce && ack_slot_r && ev.fall)
         rbyte_r <= idsel_r ? idmem[addr_r[`PAGE_BITS-1:0]] : mem[addr_r];
   end

   // sda drive decision; only pull low, never high
   always_comb
   begin
      sda_low_nxt = 1'b0;
      if (ack_slot_r && acked_r)
         sda_low_nxt = 1'b1;
      else if (phase_r == PH_RDATA && !ack_slot_r && bit_r < `BIT_CNT_LAST)
         sda_low_nxt = !rbyte_r[3'(7 - bit_r)];
   end

   // outputs from flops; data changes follow clock low only
   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
      begin
         sda_out <= 1'b0;
         sda_oe_n <= 1'b1;
         busy <= 1'b0;
         standby <= 1'b1;
      end
      else if (ce)
      begin
         sda_out <= 1'b0;
         if (ev.start || ev.stop || phase_r == PH_IDLE)
            sda_oe_n <= 1'b1;
         else if (!scl_r)
            sda_oe_n <= !sda_low_nxt;
         busy <= wr_pend_r || (ev.stop && fout_valid);
         standby <= phase_r == PH_IDLE && !wr_pend_r;
      end
   end

   a_never_high: assert property (@(posedge clk_sys) disable iff (rst) sda_out == 1'b0)
      else $error("sda driven high");
   a_busy_no_ack: assert property (@(posedge clk_sys) disable iff (rst)
      (wr_pend_r && ack_slot_r) |-> !acked_r)
      else $error("ack while busy");
   a_stop_idles: assert property (@(posedge clk_sys) disable iff (rst)
      (ce && ev.stop && !ev.start) |=> phase_r == PH_IDLE)
      else $error("stop not idling");
   a_start_arms: assert property (@(posedge clk_sys) disable iff (rst)
      (ce && ev.start && !wr_pend_r) |=> phase_r == PH_DEVADDR && bit_r == 4'h0)
      else $error("start not restarting");
   a_wp_blocks: assert property (@(posedge clk_sys) disable iff (rst)
      (write_protect && !unlocked_r) |-> !fin_valid)
      else $error("write under protect");
   a_busy_commit: assert property (@(posedge clk_sys) disable iff (rst)
      (ce && !wr_pend_r && ev.stop && fout_valid) |=> wr_pend_r && wcnt_r == CW'(WRITE_CYCLES))
      else $error("commit timer not loaded");
   a_wrap_page: assert property (@(posedge clk_sys) disable iff (rst)
      (ce && fin_valid) |=> addr_r[`ADDR_W-1:`PAGE_BITS] == $past(addr_r[`ADDR_W-1:`PAGE_BITS]))
      else $error("page bits moved");
   a_ack_drives: assert property (@(posedge clk_sys) disable iff (rst)
      (ce && ack_slot_r && acked_r && !scl_r && !ev.start && !ev.stop && phase_r != PH_IDLE) |=> !sda_oe_n)
      else $error("ack not driven");
endmodule // eeprom_slave_port

// ---- testbench/bus_master.sv ----
`timescale 1ns/10ps
// two-wire master; scl rests high between frames, sda is only released or pulled
module bus_master
(
   input wire logic sda,
   output logic scl,
   output logic sda_rel,
   output logic res_v,
   output logic [7:0] res_d
);
   initial
   begin
      scl = 1'b1;
      sda_rel = 1'b1;
      res_v = 1'b0;
      res_d = 8'h00;
   end
   // one bit, 125 ns; data moves only while scl is low
   task automatic bit_io(input logic b, output logic s);
      scl = 1'b0;
      #31 sda_rel = b;
      #31 scl = 1'b1;
      #31 s = sda;
      #32 scl = 1'b0;
   endtask
   // sda falls while scl high; also ends any broken transfer
   task automatic start();
      #31 sda_rel = 1'b1;
      #31 scl = 1'b1;
      #31 sda_rel = 1'b0;
      #31 scl = 1'b0;
   endtask
   // sda rises while scl high, then bus left idle
   task automatic stop();
      scl = 1'b0;
      #31 sda_rel = 1'b0;
      #31 scl = 1'b1;
      #31 sda_rel = 1'b1;
      #62;
   endtask
   task automatic post(input logic [7:0] d);
      res_d = d;
      res_v = 1'b1;
      #1 res_v = 1'b0;
   endtask
   // msb first, then the ack bit is reported
   task automatic wbyte(input logic [7:0] b);
      logic s;
      for (int i = 7; i >= 0; i--) bit_io(b[i], s);
      bit_io(1'b1, s);
      post({7'h00, s});
   endtask
   // read byte left unacknowledged before the stop
   task automatic rbyte();
      logic [7:0] d;
      logic s;
      for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
      bit_io(1'b1, s);
      post(d);
   endtask
endmodule // bus_master

// ---- testbench/serial_eeprom_slave_port_tb.sv ----
`timescale 1ns/10ps
module serial_eeprom_slave_port_tb;
   import eeprom_port_pkg::*;
   localparam int WCYC = 250;
   logic clk_sys = 1'b0;
   logic rst = 1'b1;
   logic write_protect = 1'b0;
   logic unlock_dev_reg = 1'b0;
   logic sda_out, sda_oe_n, busy, standby, scl, sda_rel, res_v;
   logic [7:0] res_d, d;
   logic [7:0] lfsr = 8'h1B;
   logic [7:0] mem [2048];
   logic [7:0] expq [$];
   int mismatches = 0;
   int checks_done = 0;
   // wired-and bus with pull-up; device may only pull low
   wire sda = sda_rel & (sda_oe_n | sda_out);
   eeprom_slave_port #(.WRITE_TIME_NS(2000)) uut (.clk_sys(clk_sys), .rst(rst), .ce(1'b1), .scl_in(scl),
      .sda_in(sda), .sda_out(sda_out), .sda_oe_n(sda_oe_n), .write_protect(write_protect),
      .unlock_dev_reg(unlock_dev_reg), .busy(busy), .standby(standby));
   bus_master bm (.sda(sda), .scl(scl), .sda_rel(sda_rel), .res_v(res_v), .res_d(res_d));
   initial
   begin
      forever #4 clk_sys = ~clk_sys;
   end
   function automatic logic [7:0] nxt();
      lfsr = {lfsr[6:0], lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3]};
      return lfsr;
   endfunction
   task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
      checks_done++;
      if (e !== g)
      begin
         mismatches++;
         $display("BAD %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic finish_test();
      $display("mismatches %0d checks_done %0d", mismatches, checks_done);
      if (mismatches == 0 && checks_done > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   // oldest note is compared with every ack bit or read byte seen
   always @(posedge res_v)
   begin
      if (expq.size() == 0)
         chk("unexpected_result", 8'hEE, res_d);
      else
         chk("bus_result", expq.pop_front(), res_d);
   end
   task automatic send(input logic [7:0] b, input logic nack);
      expq.push_back({7'h00, nack});
      bm.wbyte(b);
   endtask
   task automatic waitprog(input logic p);
      int n;
      n = 0;
      repeat (10) @(negedge clk_sys);
      if (p)
      begin
         chk("busy", 8'h01, {7'h00, busy});
         chk("standby", 8'h00, {7'h00, standby});
         bm.start();
         send(8'hA0, 1'b1);
         bm.stop();
      end
      while (busy !== 1'b0 && n < WCYC + 100)
      begin
         @(negedge clk_sys);
         n++;
      end
      if (!p) repeat (WCYC + 20) @(negedge clk_sys);
      chk("busy_end", 8'h00, {7'h00, busy});
      chk("standby_end", 8'h01, {7'h00, standby});
      if (p)
      begin
         bm.start();
         send(8'hA0, 1'b0);
         bm.stop();
      end
   endtask
   // block bits ride in the address byte
   task automatic bwrite(input logic [10:0] a, input logic [7:0] v, input logic p);
      bm.start();
      send({4'hA, a[10:8], 1'b0}, 1'b0);
      send(a[7:0], 1'b0);
      send(v, 1'b0);
      bm.stop();
      waitprog(p);
   endtask
   // block bits of the read address replace the counter's top bits, so name them
   task automatic cread(input logic [2:0] blk, input logic [7:0] e);
      bm.start();
      send({4'hA, blk, 1'b1}, 1'b0);
      expq.push_back(e);
      bm.rbyte();
      bm.stop();
      repeat (10) @(negedge clk_sys);
      chk("standby_read", 8'h01, {7'h00, standby});
   endtask
   initial
   begin
      // about eight times the expected run, well under the cycle budget
      #600_000;
      mismatches++;
      finish_test();
   end
   initial
   begin
      repeat (16) @(negedge clk_sys);
      rst = 1'b0;
      repeat (5) @(negedge clk_sys);
      chk("standby_reset", 8'h01, {7'h00, standby});
      d = nxt();
      mem[0] = d;
      bwrite(11'h000, d, 1'b1);
      // page from offset 8 wraps to offset 0 within the page
      bm.start();
      send(8'hAE, 1'b0);
      send(8'hF8, 1'b0);
      for (int i = 0; i < 16; i++)
      begin
         d = nxt();
         mem[{7'h7F, 4'(8 + i)}] = d;
         send(d, 1'b0);
      end
      bm.stop();
      waitprog(1'b1);
      @(negedge clk_sys);
      write_protect = 1'b1;
      bwrite(11'h7FE, ~mem[11'h7FE], 1'b0);
      @(negedge clk_sys);
      write_protect = 1'b0;
      d = nxt();
      mem[11'h7FD] = d;
      bwrite(11'h7FD, d, 1'b1);
      cread(3'h7, mem[11'h7FE]);
      cread(3'h7, mem[11'h7FF]);
      // counter rolled from the top; block zero in the address keeps it at zero
      cread(3'h0, mem[11'h000]);
      bm.start();
      send(8'h91, 1'b1);
      bm.stop();
      // once unlocked, a high protect pin no longer blocks writes
      @(negedge clk_sys);
      unlock_dev_reg = 1'b1;
      write_protect = 1'b1;
      d = nxt();
      mem[11'h7FD] = d;
      bwrite(11'h7FD, d, 1'b1);
      bwrite(11'h7FC, nxt(), 1'b1);
      cread(3'h7, mem[11'h7FD]);
      finish_test();
   end
endmodule // serial_eeprom_slave_port_tb
